// [cksie_defs.vh]
// Purpose: shared constants of the clock-system interrupt enable block
// Assumes: 32-bit register words on a byte-addressed bus
// Notes:   offsets are byte addresses; reserved bits read as zero
`ifndef CKSIE_DEFS_VH
`define CKSIE_DEFS_VH

// register byte offsets
`define CKSIE_OFS_EN_CLR      8'h00
`define CKSIE_OFS_EN_SET      8'h04
`define CKSIE_OFS_FLAG        8'h08
`define CKSIE_OFS_STATUS      8'h0C
`define CKSIE_OFS_WPROT       8'h10
`define CKSIE_OFS_PEND        8'h14

// number of interrupt sources
`define CKSIE_NSRC            12

// source bit positions
`define CKSIE_BIT_XTAL_RDY    0
`define CKSIE_BIT_XT32K_RDY   1
`define CKSIE_BIT_RC32K_RDY   2
`define CKSIE_BIT_RC8M_RDY    3
`define CKSIE_BIT_FLL_RDY     4
`define CKSIE_BIT_FLL_OOB     5
`define CKSIE_BIT_FLL_FINE    6
`define CKSIE_BIT_FLL_COARSE  7
`define CKSIE_BIT_FLL_REFSTP  8
`define CKSIE_BIT_BO_RDY      9
`define CKSIE_BIT_BO_DET      10
`define CKSIE_BIT_BO_SYNC     11

// write-protect register fields
`define CKSIE_BIT_WP_LOCK     0
`define CKSIE_BIT_WP_VIOL     1

// reset values
`define CKSIE_RST_EN          12'h000
`define CKSIE_RST_FLAG        12'h000
`define CKSIE_RST_WPROT       1'b0

// bus responses
`define CKSIE_RESP_OKAY       2'b00
`define CKSIE_RESP_SLVERR     2'b10
`define CKSIE_RESP_DECERR     2'b11

`endif

// [cksie_axil_slave.v]
// Purpose: AXI4-Lite slave front end; turns bus beats into register strobes
// Assumes: one write and one read outstanding at most
// Notes:   address and data may arrive in either order
`timescale 1ns/1ps
`include "cksie_defs.vh"
module cksie_axil_slave #(
   parameter AW = 8
) (
   input  wire          aclk,     // bus clock
   input  wire          aresetn,  // sync reset, active low
   input  wire [AW-1:0] awaddr,   // write address
   input  wire          awvalid,  // write address valid
   output wire          awready,  // write address ready
   input  wire [31:0]   wdata,    // write data
   input  wire [3:0]    wstrb,    // write byte strobes
   input  wire          wvalid,   // write data valid
   output wire          wready,   // write data ready
   output reg  [1:0]    bresp,    // write response
   output reg           bvalid,   // write response valid
   input  wire          bready,   // write response ready
   input  wire [AW-1:0] araddr,   // read address
   input  wire          arvalid,  // read address valid
   output wire          arready,  // read address ready
   output reg  [31:0]   rdata,    // read data
   output reg  [1:0]    rresp,    // read response
   output reg           rvalid,   // read data valid
   input  wire          rready,   // read data ready
   output wire          wr_req,   // one-cycle write strobe
   output wire [AW-1:0] wr_addr,  // write address to regs
   output wire [31:0]   wr_data,  // write data to regs
   output wire [3:0]    wr_strb,  // write strobes to regs
   input  wire [1:0]    wr_resp,  // response for this write
   output wire          rd_req,   // one-cycle read strobe
   output wire [AW-1:0] rd_addr,  // read address to regs
   input  wire [31:0]   rd_data,  // read data from regs
   input  wire [1:0]    rd_resp   // response for this read
);
   reg          aw_got_reg;
   reg          w_got_reg;
   reg [AW-1:0] aw_addr_reg;
   reg [31:0]   w_data_reg;
   reg [3:0]    w_strb_reg;
   wire         aw_hs;
   wire         w_hs;

   // no new beat is taken while a response waits, so at most one is in flight
   assign awready = ~aw_got_reg & ~bvalid;
   assign wready  = ~w_got_reg & ~bvalid;
   assign aw_hs   = awvalid & awready;
   assign w_hs    = wvalid & wready;
   assign wr_req  = (aw_got_reg | aw_hs) & (w_got_reg | w_hs) & ~bvalid;
   assign wr_addr = aw_got_reg ? aw_addr_reg : awaddr;
   assign wr_data = w_got_reg ? w_data_reg : wdata;
   assign wr_strb = w_got_reg ? w_strb_reg : wstrb;

   assign arready = ~rvalid;
   assign rd_req  = arvalid & arready;
   assign rd_addr = araddr;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_reg  <= 1'b0;
         w_got_reg   <= 1'b0;
         aw_addr_reg <= {AW{1'b0}};
         w_data_reg  <= 32'h00000000;
         w_strb_reg  <= 4'h0;
         bvalid      <= 1'b0;
         bresp       <= `CKSIE_RESP_OKAY;
      end else begin
         if (wr_req) begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            bvalid     <= 1'b1;
            bresp      <= wr_resp;
         end else begin
            if (aw_hs) begin
               aw_got_reg  <= 1'b1;
               aw_addr_reg <= awaddr;
            end
            if (w_hs) begin
               w_got_reg  <= 1'b1;
               w_data_reg <= wdata;
               w_strb_reg <= wstrb;
            end
            if (bvalid && bready) begin
               bvalid <= 1'b0;
            end
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= `CKSIE_RESP_OKAY;
      end else if (rd_req) begin
         rvalid <= 1'b1;
         rdata  <= rd_data;
         rresp  <= rd_resp;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule

// [cksie_irq_regs.v]
// Purpose: interrupt enable set/clear, flags and request of the clock system
// Assumes: status inputs come from oscillator logic outside the aclk domain
// Notes:   flags and enables are plain flip-flops; request output registered
// Summary of operation
// - enable set at 0x04, zero reset, protected
// - writing zero leaves an enable unchanged
// - bit 11 enables brownout sync ready request
// - bit 10 enables brownout detect request
// - bit 9 enables brownout ready request
// - bit 8 enables reference clock stopped request
// - bit 7 enables locked loop coarse request
// - bit 6 enables locked loop fine request
// - bit 5 enables locked loop out-of-bounds request
// - bit 4 enables locked loop ready request
// - bit 3 enables 8 MHz oscillator ready request
// - bit 0 enables crystal ready request
// - bits 2, 1 enable 32 kHz ready requests
// - flag sets on rising status, write-one clears
// - clear register write-one disables an enable
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cksie_defs.vh"
module cksie_irq_regs #(
   parameter AW   = 8,
   parameter NSRC = `CKSIE_NSRC
) (
   input  wire            aclk,         // 125 MHz bus clock
   input  wire            aresetn,      // sync reset, active low
   input  wire [AW-1:0]   s_awaddr,     // write address
   input  wire            s_awvalid,    // write address valid
   output wire            s_awready,    // write address ready
   input  wire [31:0]     s_wdata,      // write data
   input  wire [3:0]      s_wstrb,      // write byte strobes
   input  wire            s_wvalid,     // write data valid
   output wire            s_wready,     // write data ready
   output wire [1:0]      s_bresp,      // write response
   output wire            s_bvalid,     // write response valid
   input  wire            s_bready,     // write response ready
   input  wire [AW-1:0]   s_araddr,     // read address
   input  wire            s_arvalid,    // read address valid
   output wire            s_arready,    // read address ready
   output wire [31:0]     s_rdata,      // read data
   output wire [1:0]      s_rresp,      // read response
   output wire            s_rvalid,     // read data valid
   input  wire            s_rready,     // read data ready
   input  wire [NSRC-1:0] power_clock_status, // raw status levels, async
   output wire [NSRC-1:0] irq_src_req,  // per-source request, registered
   output wire            irq           // combined request, level, active high
);
   wire            wr_req;
   wire [AW-1:0]   wr_addr;
   wire [31:0]     wr_data;
   wire [3:0]      wr_strb;
   reg  [1:0]      wr_resp;
   wire            rd_req;
   wire [AW-1:0]   rd_addr;
   reg  [31:0]     rd_data;
   reg  [1:0]      rd_resp;

   reg  [NSRC-1:0] enable_reg;
   wire [NSRC-1:0] enable_next;
   reg  [NSRC-1:0] irq_flag_reg;
   wire [NSRC-1:0] irq_flag_next;
   reg             wp_lock_reg;
   reg             wp_lock_next;
   reg             wp_viol_reg;
   reg             wp_viol_next;
   reg  [NSRC-1:0] stat_meta_reg;
   reg  [NSRC-1:0] stat_sync_reg;
   reg  [NSRC-1:0] stat_prev_reg;
   reg  [NSRC-1:0] src_req_reg;
   reg             irq_reg;

   wire [31:0]     strb_mask;
   wire [31:0]     wr_bits;
   wire [NSRC-1:0] wr_ones;
   wire [NSRC-1:0] status_rise;
   wire [NSRC-1:0] flag_clr;
   wire [NSRC-1:0] en_set;
   wire [NSRC-1:0] en_clr;
   wire [NSRC-1:0] pend;
   wire [NSRC-1:0] src_req;
   wire            hit_en_clr;
   wire            hit_en_set;
   wire            hit_flag;
   wire            hit_wprot;
   wire            wr_blocked;

   cksie_axil_slave #(
      .AW (AW)
   ) u_bus (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (s_awaddr),
      .awvalid (s_awvalid),
      .awready (s_awready),
      .wdata   (s_wdata),
      .wstrb   (s_wstrb),
      .wvalid  (s_wvalid),
      .wready  (s_wready),
      .bresp   (s_bresp),
      .bvalid  (s_bvalid),
      .bready  (s_bready),
      .araddr  (s_araddr),
      .arvalid (s_arvalid),
      .arready (s_arready),
      .rdata   (s_rdata),
      .rresp   (s_rresp),
      .rvalid  (s_rvalid),
      .rready  (s_rready),
      .wr_req  (wr_req),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_resp (wr_resp),
      .rd_req  (rd_req),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_resp (rd_resp)
   );

   // byte lanes not strobed carry no ones, so they never set or clear anything
   assign strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   assign wr_bits   = wr_data & strb_mask;
   assign wr_ones   = wr_bits[NSRC-1:0];

   assign hit_en_clr = wr_req & (wr_addr == `CKSIE_OFS_EN_CLR);
   assign hit_en_set = wr_req & (wr_addr == `CKSIE_OFS_EN_SET);
   assign hit_flag   = wr_req & (wr_addr == `CKSIE_OFS_FLAG);
   assign hit_wprot  = wr_req & (wr_addr == `CKSIE_OFS_WPROT);

   // protected enables refuse both set and clear while locked
   assign wr_blocked = (hit_en_set | hit_en_clr) & wp_lock_reg;

   // only ones act; a zero bit in the word leaves the enable alone
   assign en_set   = (hit_en_set & ~wp_lock_reg) ? wr_ones : {NSRC{1'b0}};
   assign en_clr   = (hit_en_clr & ~wp_lock_reg) ? wr_ones : {NSRC{1'b0}};
   assign flag_clr = hit_flag ? wr_ones : {NSRC{1'b0}};

   // status levels cross from the oscillator domain; edge taken after sync
   always @(posedge aclk) begin
      if (!aresetn) begin
         stat_meta_reg <= {NSRC{1'b0}};
         stat_sync_reg <= {NSRC{1'b0}};
         stat_prev_reg <= {NSRC{1'b0}};
      end else begin
         stat_meta_reg <= power_clock_status;
         stat_sync_reg <= stat_meta_reg;
         stat_prev_reg <= stat_sync_reg;
      end
   end

   // a status already high at reset release still raises its flag: prev
   // clears with reset while sync catches up two cycles later
   assign status_rise = stat_sync_reg & ~stat_prev_reg;

   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_src
         // a rise in the same cycle as a write-one clear keeps the flag set
         assign irq_flag_next[gi] = (irq_flag_reg[gi] & ~flag_clr[gi]) | status_rise[gi];
         // one stored enable, reached from both the set and the clear port
         assign enable_next[gi] = (enable_reg[gi] & ~en_clr[gi]) | en_set[gi];
      end
   endgenerate

   assign pend = irq_flag_reg & enable_reg;

   // per-source request: flag present and its enable high
   assign src_req[`CKSIE_BIT_BO_SYNC]    = pend[`CKSIE_BIT_BO_SYNC];
   assign src_req[`CKSIE_BIT_BO_DET]     = pend[`CKSIE_BIT_BO_DET];
   assign src_req[`CKSIE_BIT_BO_RDY]     = pend[`CKSIE_BIT_BO_RDY];
   assign src_req[`CKSIE_BIT_FLL_REFSTP] = pend[`CKSIE_BIT_FLL_REFSTP];
   assign src_req[`CKSIE_BIT_FLL_COARSE] = pend[`CKSIE_BIT_FLL_COARSE];
   assign src_req[`CKSIE_BIT_FLL_FINE]   = pend[`CKSIE_BIT_FLL_FINE];
   assign src_req[`CKSIE_BIT_FLL_OOB]    = pend[`CKSIE_BIT_FLL_OOB];
   assign src_req[`CKSIE_BIT_FLL_RDY]    = pend[`CKSIE_BIT_FLL_RDY];
   assign src_req[`CKSIE_BIT_RC8M_RDY]   = pend[`CKSIE_BIT_RC8M_RDY];
   assign src_req[`CKSIE_BIT_RC32K_RDY]  = pend[`CKSIE_BIT_RC32K_RDY];
   assign src_req[`CKSIE_BIT_XT32K_RDY]  = pend[`CKSIE_BIT_XT32K_RDY];
   assign src_req[`CKSIE_BIT_XTAL_RDY]   = pend[`CKSIE_BIT_XTAL_RDY];

   // write-protect control: lock bit plain r/w, violation bit sticky
   always @* begin
      wp_lock_next = wp_lock_reg;
      wp_viol_next = wp_viol_reg;
      if (hit_wprot && wr_strb[0]) begin
         wp_lock_next = wr_data[`CKSIE_BIT_WP_LOCK];
         if (wr_data[`CKSIE_BIT_WP_VIOL]) begin
            wp_viol_next = 1'b0;
         end
      end
      // a refused write in the clearing cycle still leaves the mark
      if (wr_blocked) begin
         wp_viol_next = 1'b1;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         enable_reg   <= `CKSIE_RST_EN;
         irq_flag_reg <= `CKSIE_RST_FLAG;
         wp_lock_reg  <= `CKSIE_RST_WPROT;
         wp_viol_reg  <= 1'b0;
         src_req_reg  <= {NSRC{1'b0}};
         irq_reg      <= 1'b0;
      end else begin
         enable_reg   <= enable_next;
         irq_flag_reg <= irq_flag_next;
         wp_lock_reg  <= wp_lock_next;
         wp_viol_reg  <= wp_viol_next;
         src_req_reg  <= src_req;
         irq_reg      <= |src_req;
      end
   end

   assign irq_src_req = src_req_reg;
   assign irq         = irq_reg;

   // write answer: locked enable writes and offsets other than enable, flag and write-protect are refused
   always @* begin
      wr_resp = `CKSIE_RESP_OKAY;
      if (wr_blocked) begin
         wr_resp = `CKSIE_RESP_SLVERR;
      end else if (!(hit_en_clr | hit_en_set | hit_flag | hit_wprot)) begin
         wr_resp = `CKSIE_RESP_DECERR;
      end
   end

   // read mux; reserved bits read as zero
   always @* begin
      rd_data = 32'h00000000;
      rd_resp = `CKSIE_RESP_OKAY;
      case (rd_addr)
         `CKSIE_OFS_EN_CLR: begin
            rd_data[NSRC-1:0] = enable_reg;
         end
         `CKSIE_OFS_EN_SET: begin
            rd_data[NSRC-1:0] = enable_reg;
         end
         `CKSIE_OFS_FLAG: begin
            rd_data[NSRC-1:0] = irq_flag_reg;
         end
         `CKSIE_OFS_STATUS: begin
            rd_data[NSRC-1:0] = stat_sync_reg;
         end
         `CKSIE_OFS_WPROT: begin
            rd_data[`CKSIE_BIT_WP_LOCK] = wp_lock_reg;
            rd_data[`CKSIE_BIT_WP_VIOL] = wp_viol_reg;
         end
         `CKSIE_OFS_PEND: begin
            rd_data[NSRC-1:0] = pend;
         end
         default: begin
            rd_resp = `CKSIE_RESP_DECERR;
         end
      endcase
   end

   // rd_req is unused beyond the slave: reads here have no side effects
   wire unused_rd_req;
   assign unused_rd_req = rd_req;
endmodule

// [cksie_irq_regs_properties.sv]
// Purpose: port-level checks of the clock-system interrupt enable block
// Assumes: one clock, synchronous active-low reset
// Notes:   a write is judged only when address and data are taken at one edge
`timescale 1ns/1ps
`include "cksie_defs.vh"
module cksie_irq_props #(
   parameter AW   = 8,
   parameter NSRC = 12
) (
   input wire            aclk,               // bus clock
   input wire            aresetn,            // sync reset, active low
   input wire [AW-1:0]   s_awaddr,           // write address
   input wire            s_awvalid,          // write address valid
   input wire            s_awready,          // write address ready
   input wire [31:0]     s_wdata,            // write data
   input wire [3:0]      s_wstrb,            // write strobes
   input wire            s_wvalid,           // write data valid
   input wire            s_wready,           // write data ready
   input wire [1:0]      s_bresp,            // write response
   input wire            s_bvalid,           // write response valid
   input wire            s_bready,           // write response ready
   input wire [AW-1:0]   s_araddr,           // read address
   input wire            s_arvalid,          // read address valid
   input wire            s_arready,          // read address ready
   input wire [31:0]     s_rdata,            // read data
   input wire [1:0]      s_rresp,            // read response
   input wire            s_rvalid,           // read data valid
   input wire            s_rready,           // read data ready
   input wire [NSRC-1:0] power_clock_status, // raw status
   input wire [NSRC-1:0] irq_src_req,        // per-source request
   input wire            irq                 // combined request
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire wr_take = s_awvalid & s_awready & s_wvalid & s_wready;
   wire rd_take = s_arvalid & s_arready;

   reset_clear_a: assert property ($rose(aresetn) |-> !s_bvalid && !s_rvalid && !irq && irq_src_req == 0)
      else $error("outputs not clear after reset");
   write_answer_a: assert property (wr_take |=> s_bvalid && !s_awready && !s_wready)
      else $error("write not answered next cycle");
   bresp_fall_a: assert property ($fell(s_bvalid) |-> $past(s_bready))
      else $error("write response dropped without bready");
   read_answer_a: assert property (rd_take |=> s_rvalid)
      else $error("read not answered next cycle");
   rvalid_fall_a: assert property ($fell(s_rvalid) |-> $past(s_rready))
      else $error("read data dropped without rready");
   read_gate_a: assert property (s_arready == !s_rvalid)
      else $error("read ready not inverse of rvalid");
   set_read_a: assert property (rd_take && s_araddr == `CKSIE_OFS_EN_SET |=>
      s_rresp == `CKSIE_RESP_OKAY && s_rdata[31:12] == 20'h00000)
      else $error("enable set read bad response or upper bits");
   irq_join_a: assert property (irq == (|irq_src_req))
      else $error("irq differs from or of source requests");
   zero_write_a: assert property (wr_take && s_awaddr == `CKSIE_OFS_EN_SET && s_wdata[11:0] == 12'h000 |=>
      ##1 (irq_src_req & $past(irq_src_req)) == $past(irq_src_req))
      else $error("zero write dropped an enabled request");
   unmapped_wr_a: assert property (wr_take && s_awaddr == `CKSIE_OFS_STATUS |=>
      s_bresp == `CKSIE_RESP_DECERR)
      else $error("write to read-only place not refused");
endmodule

bind cksie_irq_regs cksie_irq_props #(.AW(AW), .NSRC(NSRC)) cksie_irq_props_i (
   .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
   .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
   .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
   .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
   .power_clock_status(power_clock_status), .irq_src_req(irq_src_req), .irq(irq));

// [clock_sys_irq_enable_set_test.sv]
// Purpose: self-checking bench of the clock-system interrupt enable block
// Assumes: bench is the AXI4-Lite master and the status source
// Notes:   ready is sampled mid-cycle; inputs do not move before the next edge
`timescale 1ns/1ps
`include "cksie_defs.vh"
module clock_sys_irq_enable_set_test;
   reg         aclk;
   reg         aresetn;
   reg  [7:0]  s_awaddr;
   reg         s_awvalid;
   reg  [31:0] s_wdata;
   reg  [3:0]  s_wstrb;
   reg         s_wvalid;
   reg         s_bready;
   reg  [7:0]  s_araddr;
   reg         s_arvalid;
   reg         s_rready;
   reg  [11:0] pcs;
   reg  [11:0] en_acc;
   wire        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
   wire [1:0]  s_bresp, s_rresp;
   wire [31:0] s_rdata;
   wire [11:0] irq_src_req;
   integer     err_total, comparisons, i;
   integer     cyc = 0;

   cksie_irq_regs cksie_irq_regs_i (
      .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
      .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
      .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
      .s_rready(s_rready), .power_clock_status(pcs), .irq_src_req(irq_src_req), .irq(irq));

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   task finish_test;
      begin
         $display("comparisons %0d, errors %0d", comparisons, err_total);
         if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask

   // a hang in a handshake loop ends here
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total = err_total + 1;
         finish_test;
      end
   end

   task check(input [31:0] seen, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
         end
      end
   endtask

   task wr_chk(input [7:0] a, input [31:0] d, input [1:0] exp_r);
      reg aw_hit, w_hit, b_hit;
      reg [1:0] r;
      begin
         b_hit = 1'b0;
         @(posedge aclk);
         s_awaddr  <= a;
         s_wdata   <= d;
         s_awvalid <= 1'b1;
         s_wvalid  <= 1'b1;
         s_bready  <= 1'b1;
         while (!b_hit) begin
            @(negedge aclk);
            aw_hit = s_awvalid & s_awready;
            w_hit  = s_wvalid & s_wready;
            b_hit  = s_bvalid;
            r      = s_bresp;
            @(posedge aclk);
            if (aw_hit) s_awvalid <= 1'b0;
            if (w_hit) s_wvalid <= 1'b0;
         end
         s_bready <= 1'b0;
         check(r, exp_r);
      end
   endtask

   task rd_chk(input [7:0] a, input [31:0] exp_d, input [1:0] exp_r);
      reg ar_hit, r_hit;
      reg [31:0] d;
      reg [1:0] r;
      begin
         r_hit = 1'b0;
         @(posedge aclk);
         s_araddr  <= a;
         s_arvalid <= 1'b1;
         s_rready  <= 1'b1;
         while (!r_hit) begin
            @(negedge aclk);
            ar_hit = s_arvalid & s_arready;
            r_hit  = s_rvalid;
            d      = s_rdata;
            r      = s_rresp;
            @(posedge aclk);
            if (ar_hit) s_arvalid <= 1'b0;
         end
         s_rready <= 1'b0;
         check(d, exp_d);
         check(r, exp_r);
      end
   endtask

   initial begin
      {aresetn, s_awaddr, s_awvalid, s_wdata, s_wvalid, s_bready} = 0;
      {s_araddr, s_arvalid, s_rready, pcs, en_acc} = 0;
      s_wstrb = 4'hF;
      err_total = 0;
      comparisons = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(`CKSIE_OFS_EN_SET, 32'h0, `CKSIE_RESP_OKAY);
      check(irq_src_req, 12'h000);
      // each source: flag alone must not request, enable then must
      for (i = 0; i < 12; i = i + 1) begin
         @(posedge aclk);
         pcs[i] <= 1'b1;
         repeat (6) @(negedge aclk);
         check(irq_src_req, en_acc);
         wr_chk(`CKSIE_OFS_EN_SET, 32'h1 << i, `CKSIE_RESP_OKAY);
         en_acc = en_acc | (12'h001 << i);
         repeat (2) @(negedge aclk);
         check(irq_src_req, en_acc);
         check(irq, 1'b1);
         rd_chk(`CKSIE_OFS_EN_SET, {20'h0, en_acc}, `CKSIE_RESP_OKAY);
      end
      wr_chk(`CKSIE_OFS_EN_SET, 32'h0, `CKSIE_RESP_OKAY);
      rd_chk(`CKSIE_OFS_EN_SET, 32'hFFF, `CKSIE_RESP_OKAY);
      wr_chk(`CKSIE_OFS_EN_CLR, 32'h0F0, `CKSIE_RESP_OKAY);
      rd_chk(`CKSIE_OFS_EN_SET, 32'hF0F, `CKSIE_RESP_OKAY);
      rd_chk(`CKSIE_OFS_EN_CLR, 32'hF0F, `CKSIE_RESP_OKAY);
      check(irq_src_req, 12'hF0F);
      wr_chk(`CKSIE_OFS_FLAG, 32'hFFF, `CKSIE_RESP_OKAY);
      rd_chk(`CKSIE_OFS_FLAG, 32'h0, `CKSIE_RESP_OKAY);
      check(irq, 1'b0);
      @(posedge aclk);
      pcs[11] <= 1'b0;
      repeat (3) @(posedge aclk);
      pcs[11] <= 1'b1;
      repeat (6) @(negedge aclk);
      check(irq_src_req, 12'h800);
      check(irq, 1'b1);
      // locked: set port refuses and keeps its enables
      wr_chk(`CKSIE_OFS_WPROT, 32'h1, `CKSIE_RESP_OKAY);
      wr_chk(`CKSIE_OFS_EN_SET, 32'h0F0, `CKSIE_RESP_SLVERR);
      rd_chk(`CKSIE_OFS_EN_SET, 32'hF0F, `CKSIE_RESP_OKAY);
      rd_chk(`CKSIE_OFS_WPROT, 32'h3, `CKSIE_RESP_OKAY);
      wr_chk(`CKSIE_OFS_WPROT, 32'h2, `CKSIE_RESP_OKAY);
      wr_chk(`CKSIE_OFS_EN_SET, 32'h0F0, `CKSIE_RESP_OKAY);
      rd_chk(`CKSIE_OFS_EN_SET, 32'hFFF, `CKSIE_RESP_OKAY);
      wr_chk(`CKSIE_OFS_STATUS, 32'h1, `CKSIE_RESP_DECERR);
      rd_chk(8'h40, 32'h0, `CKSIE_RESP_DECERR);
      rd_chk(`CKSIE_OFS_STATUS, 32'hFFF, `CKSIE_RESP_OKAY);
      // only byte lane 0 strobed: bits 11:8 of the word must not clear
      s_wstrb <= 4'h1;
      wr_chk(`CKSIE_OFS_EN_CLR, 32'hF0F, `CKSIE_RESP_OKAY);
      s_wstrb <= 4'hF;
      rd_chk(`CKSIE_OFS_EN_SET, 32'hFF0, `CKSIE_RESP_OKAY);
      rd_chk(`CKSIE_OFS_PEND, 32'h800, `CKSIE_RESP_OKAY);
      check(irq_src_req, 12'h800);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(`CKSIE_OFS_EN_SET, 32'h0, `CKSIE_RESP_OKAY);
      check(irq, 1'b0);
      finish_test;
   end
endmodule
